// ### rtl/ddrcsl_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module ddrcsl_ctrl (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Request port
   input wire logic i_req_valid,
   input wire ddrcsl_pkg::ddrcsl_req_t i_req_kind,
   input wire logic [ddrcsl_pkg::BA_W-1:0] i_req_ba,
   input wire logic [ddrcsl_pkg::ADDR_W-1:0] i_req_addr,
   output logic o_req_ready,
   output logic o_req_done,
   output logic o_req_reject,
   // Command link
   ddrcsl_if.ctrl lnk
);
   import ddrcsl_pkg::*;

   // Link clock divider, commands change on falling edge
   logic [2:0] div_ff;
   logic ck_ff;
   wire div_end = (div_ff == LINK_HALF - 3'h1);
   wire slot = div_end & ck_ff;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         div_ff <= 3'h0;
         ck_ff <= 1'b0;
      end else begin
         div_ff <= div_end ? 3'h0 : div_ff + 3'h1;
         if (div_end) ck_ff <= ~ck_ff;
      end
   end

   // Bank tracking for legality
   ddrcsl_bank_t bk_ff [NUM_BANKS];
   logic [TMR_W-1:0] bt_ff [NUM_BANKS];
   logic [TMR_W-1:0] gt_ff;
   logic sleep_ff, sref_ff;
   logic all_idle;
   always_comb begin
      all_idle = 1'b1;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (bk_ff[i] != DDRCSL_BK_IDLE) all_idle = 1'b0;
      end
   end
   wire ddrcsl_bank_t cb = bk_ff[i_req_ba];
   wire cmd_act = (cb == DDRCSL_BK_IDLE);
   wire cmd_col = (cb == DDRCSL_BK_ACT) |
                  ((cb == DDRCSL_BK_WREC) & (i_req_kind == DDRCSL_REQ_WR));
   wire cmd_pre = (cb == DDRCSL_BK_ACT) | (cb == DDRCSL_BK_IDLE) |
                  (cb == DDRCSL_BK_PRE);
   wire pre_all_ok = all_idle | ~(|gt_ff);
   logic legal;
   always_comb begin
      legal = 1'b0;
      case (i_req_kind)
         DDRCSL_REQ_NOP: legal = 1'b1;
         DDRCSL_REQ_ACT: legal = cmd_act;
         DDRCSL_REQ_RD, DDRCSL_REQ_BST: legal = (cb == DDRCSL_BK_ACT);
         DDRCSL_REQ_WR: legal = cmd_col;
         DDRCSL_REQ_PRE: legal = cmd_pre;
         DDRCSL_REQ_PREA: legal = pre_all_ok;
         DDRCSL_REQ_REF, DDRCSL_REQ_MRS, DDRCSL_REQ_SREF, DDRCSL_REQ_PDN:
            legal = all_idle;
         default: legal = 1'b0;
      endcase
      if (sleep_ff) legal = (i_req_kind == DDRCSL_REQ_WAKE);
      else if (i_req_kind == DDRCSL_REQ_WAKE) legal = 1'b0;
   end
   wire busy = (gt_ff != '0);
   wire take = slot & i_req_valid & ~busy;

   // Encoded pins for the request
   logic [2:0] enc;
   always_comb begin
      case (i_req_kind)
         DDRCSL_REQ_ACT: enc = CMD_ACT;
         DDRCSL_REQ_RD: enc = CMD_RD;
         DDRCSL_REQ_WR: enc = CMD_WR;
         DDRCSL_REQ_PRE, DDRCSL_REQ_PREA: enc = CMD_PRE;
         DDRCSL_REQ_REF, DDRCSL_REQ_SREF: enc = CMD_REF;
         DDRCSL_REQ_MRS: enc = CMD_MRS;
         DDRCSL_REQ_BST: enc = CMD_BST;
         default: enc = CMD_NOP;
      endcase
   end

   // Link pins, flag outputs and global timer
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         lnk.ck <= 1'b0;
         lnk.cke <= 1'b0;
         {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} <= 4'hf;
         lnk.ba <= '0;
         lnk.addr <= '0;
         o_req_done <= 1'b0;
         o_req_reject <= 1'b0;
         o_req_ready <= 1'b0;
         gt_ff <= '0;
         sleep_ff <= 1'b0;
         sref_ff <= 1'b0;
      end else begin
         lnk.ck <= ck_ff;
         o_req_ready <= ~busy;
         o_req_done <= 1'b0;
         o_req_reject <= 1'b0;
         if (slot & (gt_ff != '0)) gt_ff <= gt_ff - 1'b1;
         if (slot) begin
            lnk.cke <= 1'b1;
            {lnk.cs_n, lnk.ras_n, lnk.cas_n, lnk.we_n} <= 4'hf;
            if (sleep_ff) lnk.cke <= 1'b0;
         end
         if (take & ~legal) o_req_reject <= 1'b1;
         if (take & legal) begin
            o_req_done <= 1'b1;
            {lnk.ras_n, lnk.cas_n, lnk.we_n} <= enc;
            lnk.cs_n <= (enc == CMD_NOP);
            lnk.ba <= i_req_ba;
            lnk.addr <= i_req_addr;
            if (i_req_kind == DDRCSL_REQ_PREA) lnk.addr[10] <= 1'b1;
            case (i_req_kind)
               DDRCSL_REQ_REF: gt_ff <= TMR_W'(T_RFC_CYC);
               DDRCSL_REQ_MRS: gt_ff <= TMR_W'(T_MRD_CYC);
               DDRCSL_REQ_SREF, DDRCSL_REQ_PDN: begin
                  lnk.cke <= 1'b0;
                  sleep_ff <= 1'b1;
                  sref_ff <= (i_req_kind == DDRCSL_REQ_SREF);
               end
               DDRCSL_REQ_WAKE: begin
                  lnk.cke <= 1'b1;
                  sleep_ff <= 1'b0;
                  gt_ff <= sref_ff ? TMR_W'(T_XSNR_CYC)
                                   : TMR_W'(T_PDEX_CYC);
               end
               default: gt_ff <= gt_ff;
            endcase
         end
      end
   end

   // Per-bank shadow of device state
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bk
      wire hit = take & legal & (i_req_ba == BA_W'(b));
      wire pre_me = take & legal & ((hit & (i_req_kind == DDRCSL_REQ_PRE))
                    | (i_req_kind == DDRCSL_REQ_PREA));
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            bk_ff[b] <= DDRCSL_BK_IDLE;
            bt_ff[b] <= '0;
         end else if (slot) begin
            if (bt_ff[b] != '0) bt_ff[b] <= bt_ff[b] - 1'b1;
            if (pre_me & (bk_ff[b] == DDRCSL_BK_ACT)) begin
               bk_ff[b] <= DDRCSL_BK_PRE;
               bt_ff[b] <= TMR_W'(T_RP_CYC);
            end else if (hit & (i_req_kind == DDRCSL_REQ_ACT)) begin
               bk_ff[b] <= DDRCSL_BK_ACTG;
               bt_ff[b] <= TMR_W'(T_RCD_CYC);
            end else if (hit & (i_req_kind == DDRCSL_REQ_WR)) begin
               bk_ff[b] <= DDRCSL_BK_WREC;
               bt_ff[b] <= TMR_W'(T_WR_CYC);
            end else if (bt_ff[b] == '0) begin
               case (bk_ff[b])
                  DDRCSL_BK_PRE: bk_ff[b] <= DDRCSL_BK_IDLE;
                  DDRCSL_BK_ACTG, DDRCSL_BK_WREC: bk_ff[b] <= DDRCSL_BK_ACT;
                  default: bk_ff[b] <= bk_ff[b];
               endcase
            end
         end
      end
   end
endmodule : ddrcsl_ctrl
`default_nettype wire

// ### rtl/ddrcsl_dram.sv
`timescale 1ns/1ns
`default_nettype none
module ddrcsl_dram (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Command link
   ddrcsl_if.dram lnk,
   // Status
   output logic [5:0] o_dev_state,
   output logic [4*ddrcsl_pkg::NUM_BANKS-1:0] o_bank_idle_map,
   output logic o_illegal,
   output logic o_nop_taken,
   output logic o_awake
);
   import ddrcsl_pkg::*;

   // Two-stage synchronisers for all link inputs
   logic [BA_W+ADDR_W+5:0] s1_ff, s2_ff;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_ff <= '1;
         s2_ff <= '1;
      end else begin
         s1_ff <= {lnk.ck, lnk.cke, lnk.cs_n, lnk.ras_n, lnk.cas_n,
                   lnk.we_n, lnk.ba, lnk.addr};
         s2_ff <= s1_ff;
      end
   end

   // Unpacked synchronised pins
   wire ck_s = s2_ff[BA_W+ADDR_W+5];
   wire cke_s = s2_ff[BA_W+ADDR_W+4];
   wire cs_n_s = s2_ff[BA_W+ADDR_W+3];
   wire [2:0] rcw_s = s2_ff[BA_W+ADDR_W+2:BA_W+ADDR_W];
   wire [BA_W-1:0] ba_s = s2_ff[BA_W+ADDR_W-1:ADDR_W];
   wire a10_s = s2_ff[10];

   // Link clock edge detect and clock-enable history
   logic ck_d_ff, cke_cur_ff;
   wire ck_rise = ck_s & ~ck_d_ff;
   // Edge history resets high so the reset level gives no false rise
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ck_d_ff <= 1'b1;
         cke_cur_ff <= 1'b0;
      end else begin
         ck_d_ff <= ck_s;
         if (ck_rise) cke_cur_ff <= cke_s;
      end
   end

   // Command decode
   wire [2:0] cmd = cs_n_s ? CMD_NOP : rcw_s;
   wire cke_hold = cke_cur_ff & cke_s;
   wire cke_fall = cke_cur_ff & ~cke_s;
   wire cke_rise = ~cke_cur_ff & cke_s;

   ddrcsl_dev_t dev_ff, nxt_dev;
   ddrcsl_bank_t bank_ff [NUM_BANKS];
   logic [TMR_W-1:0] btmr_ff [NUM_BANKS];
   logic [TMR_W-1:0] dtmr_ff, nxt_dtmr;
   logic all_idle;
   always_comb begin
      all_idle = 1'b1;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (bank_ff[i] != DDRCSL_BK_IDLE) all_idle = 1'b0;
      end
   end

   // Addressed bank state
   wire ddrcsl_bank_t cur_bk = bank_ff[ba_s];
   wire in_run = (dev_ff == DDRCSL_DV_RUN);
   wire bk_pre = (cur_bk == DDRCSL_BK_PRE);
   wire bk_actg = (cur_bk == DDRCSL_BK_ACTG);
   wire bk_wrec = (cur_bk == DDRCSL_BK_WREC);
   wire bk_idle = (cur_bk == DDRCSL_BK_IDLE);
   wire is_rowcol = (cmd == CMD_BST) | (cmd == CMD_RD) |
                    (cmd == CMD_WR) | (cmd == CMD_ACT);
   wire is_glob = (cmd == CMD_REF) | (cmd == CMD_MRS);
   // Illegal commands in per-state decoding
   wire ill_pre = bk_pre & is_rowcol;
   wire ill_actg = bk_actg & (is_rowcol | (cmd == CMD_PRE));
   wire ill_wrec = bk_wrec & (cmd != CMD_WR) & (cmd != CMD_NOP) &
                   ~is_glob;
   wire ill_glob = is_glob & ~all_idle;
   wire ill_busy = ~in_run & (cmd != CMD_NOP);
   wire ill_idle = bk_idle & ((cmd == CMD_RD) | (cmd == CMD_WR) |
                   (cmd == CMD_BST));
   wire ill_run = (in_run & (ill_pre | ill_actg | ill_wrec | ill_glob |
                   ill_idle)) | ill_busy;
   // Power-state decoding
   wire sr_exit_bad = (cmd != CMD_NOP);
   wire ent_sref = all_idle & (cmd == CMD_REF);
   wire ent_pdn = all_idle & (cmd == CMD_NOP);
   wire ill_ent = ~(ent_sref | ent_pdn);

   // Device state transitions
   always_comb begin
      nxt_dev = dev_ff;
      nxt_dtmr = (dtmr_ff != '0) ? dtmr_ff - 1'b1 : dtmr_ff;
      case (dev_ff)
         DDRCSL_DV_RUN: begin
            if (cke_fall & in_run & ent_sref) begin
               nxt_dev = DDRCSL_DV_SREF;
            end else if (cke_fall & ent_pdn) begin
               nxt_dev = DDRCSL_DV_PDN;
            end else if (cke_hold & (cmd == CMD_REF) & all_idle) begin
               nxt_dev = DDRCSL_DV_REF;
               nxt_dtmr = TMR_W'(T_RFC_CYC);
            end else if (cke_hold & (cmd == CMD_MRS) & all_idle) begin
               nxt_dev = DDRCSL_DV_MRS;
               nxt_dtmr = TMR_W'(T_MRD_CYC);
            end
         end
         DDRCSL_DV_REF, DDRCSL_DV_MRS, DDRCSL_DV_PDX: begin
            // Leave on the last counted rise; next rise is in run
            if (dtmr_ff <= TMR_W'(1)) nxt_dev = DDRCSL_DV_RUN;
         end
         DDRCSL_DV_SREF: begin
            if (cke_rise & ~sr_exit_bad) begin
               nxt_dev = DDRCSL_DV_PDX;
               nxt_dtmr = TMR_W'(T_XSNR_CYC);
            end
         end
         DDRCSL_DV_PDN: begin
            if (cke_rise) begin
               nxt_dev = DDRCSL_DV_PDX;
               nxt_dtmr = TMR_W'(T_PDEX_CYC);
            end
         end
         default: nxt_dev = DDRCSL_DV_RUN;
      endcase
   end

   // Device state, timer and status flags
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         dev_ff <= DDRCSL_DV_RUN;
         dtmr_ff <= '0;
         o_illegal <= 1'b0;
         o_nop_taken <= 1'b0;
      end else begin
         o_illegal <= 1'b0;
         o_nop_taken <= 1'b0;
         if (ck_rise) begin
            dev_ff <= nxt_dev;
            dtmr_ff <= nxt_dtmr;
            if (cke_hold) o_illegal <= ill_run;
            else if (cke_fall & in_run) o_illegal <= ill_ent;
            else if (cke_rise & (dev_ff == DDRCSL_DV_SREF))
               o_illegal <= sr_exit_bad;
            o_nop_taken <= cke_hold & in_run & bk_pre &
                           (cmd == CMD_PRE);
         end
      end
   end

   // Receiver wake follows clock enable without a link clock edge
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) o_awake <= 1'b1;
      else if (dev_ff == DDRCSL_DV_SREF) o_awake <= cke_s;
      else o_awake <= 1'b1;
   end

   // Per-bank state machines
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      wire hit = (ba_s == BA_W'(b));
      wire go = ck_rise & cke_hold & in_run;
      wire pre_hit = (cmd == CMD_PRE) & (hit | a10_s);
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            bank_ff[b] <= DDRCSL_BK_IDLE;
            btmr_ff[b] <= '0;
         end else if (ck_rise) begin
            if (btmr_ff[b] != '0) btmr_ff[b] <= btmr_ff[b] - 1'b1;
            case (bank_ff[b])
               DDRCSL_BK_IDLE: begin
                  if (go & hit & (cmd == CMD_ACT)) begin
                     bank_ff[b] <= DDRCSL_BK_ACTG;
                     btmr_ff[b] <= TMR_W'(T_RCD_CYC);
                  end
               end
               DDRCSL_BK_ACTG: begin
                  if (btmr_ff[b] == '0) bank_ff[b] <= DDRCSL_BK_ACT;
               end
               DDRCSL_BK_ACT: begin
                  if (go & pre_hit) begin
                     bank_ff[b] <= DDRCSL_BK_PRE;
                     btmr_ff[b] <= TMR_W'(T_RP_CYC);
                  end else if (go & hit & (cmd == CMD_WR)) begin
                     bank_ff[b] <= DDRCSL_BK_WREC;
                     btmr_ff[b] <= TMR_W'(T_WR_CYC);
                  end
               end
               DDRCSL_BK_WREC: begin
                  if (go & hit & (cmd == CMD_WR))
                     btmr_ff[b] <= TMR_W'(T_WR_CYC);
                  else if (btmr_ff[b] == '0) bank_ff[b] <= DDRCSL_BK_ACT;
               end
               DDRCSL_BK_PRE: begin
                  if (btmr_ff[b] == '0) bank_ff[b] <= DDRCSL_BK_IDLE;
               end
               default: bank_ff[b] <= DDRCSL_BK_IDLE;
            endcase
         end
      end
   end

   // Status outputs
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_dev_state <= 6'h01;
         o_bank_idle_map <= {NUM_BANKS{4'h1}};
      end else begin
         o_dev_state <= dev_ff;
         for (int i = 0; i < NUM_BANKS; i++)
            o_bank_idle_map[4*i +: 4] <= {bank_ff[i] == DDRCSL_BK_WREC,
               bank_ff[i] == DDRCSL_BK_ACT, bank_ff[i] == DDRCSL_BK_ACTG,
               bank_ff[i] == DDRCSL_BK_IDLE};
      end
   end
endmodule : ddrcsl_dram
`default_nettype wire

// ### rtl/ddrcsl_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ddrcsl_if;
   import ddrcsl_pkg::*;
   logic ck;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [BA_W-1:0] ba;
   logic [ADDR_W-1:0] addr;
   modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
   modport dram (input ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : ddrcsl_if
`default_nettype wire

// ### rtl/ddrcsl_pkg.sv
package ddrcsl_pkg;
   // Bank and address widths
   localparam int NUM_BANKS = 4;
   localparam int BA_W = 2;
   localparam int ADDR_W = 13;
   // Clock rate and derived timings
   localparam int CLK_MHZ = 20;
   localparam int T_RP_NS = 20;
   localparam int T_RCD_NS = 20;
   localparam int T_WR_NS = 15;
   localparam int T_PDEX_NS = 10;
   localparam int T_RFC_NS = 80;
   localparam int T_MRD_NS = 15;
   localparam int T_XSNR_NS = 75;
   localparam int T_RP_CYC = (T_RP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_RCD_CYC = (T_RCD_NS * CLK_MHZ + 999) / 1000;
   localparam int T_WR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
   localparam int T_PDEX_CYC = (T_PDEX_NS * CLK_MHZ + 999) / 1000;
   localparam int T_RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
   localparam int T_MRD_CYC = (T_MRD_NS * CLK_MHZ + 999) / 1000;
   localparam int T_XSNR_CYC = (T_XSNR_NS * CLK_MHZ + 999) / 1000;
   // Link clock divider half period in core cycles
   localparam logic [2:0] LINK_HALF = 3'h4;
   localparam int TMR_W = 4;
   // Command codes, ras/cas/we with chip select low
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_MRS = 3'h0;
   // Host request kinds
   typedef enum logic [3:0] {
      DDRCSL_REQ_NOP = 4'h0,
      DDRCSL_REQ_ACT = 4'h1,
      DDRCSL_REQ_RD = 4'h2,
      DDRCSL_REQ_WR = 4'h3,
      DDRCSL_REQ_PRE = 4'h4,
      DDRCSL_REQ_PREA = 4'h5,
      DDRCSL_REQ_REF = 4'h6,
      DDRCSL_REQ_MRS = 4'h7,
      DDRCSL_REQ_BST = 4'h8,
      DDRCSL_REQ_SREF = 4'h9,
      DDRCSL_REQ_PDN = 4'ha,
      DDRCSL_REQ_WAKE = 4'hb
   } ddrcsl_req_t;
   // Per-bank states, one-hot
   typedef enum logic [4:0] {
      DDRCSL_BK_IDLE = 5'h01,
      DDRCSL_BK_PRE = 5'h02,
      DDRCSL_BK_ACTG = 5'h04,
      DDRCSL_BK_ACT = 5'h08,
      DDRCSL_BK_WREC = 5'h10
   } ddrcsl_bank_t;
   // Device-wide states, one-hot
   typedef enum logic [5:0] {
      DDRCSL_DV_RUN = 6'h01,
      DDRCSL_DV_REF = 6'h02,
      DDRCSL_DV_MRS = 6'h04,
      DDRCSL_DV_SREF = 6'h08,
      DDRCSL_DV_PDN = 6'h10,
      DDRCSL_DV_PDX = 6'h20
   } ddrcsl_dev_t;
endpackage : ddrcsl_pkg

// ### tb/ddrcsl_props.sv
`timescale 1ns/1ns
`default_nettype none
module ddrcsl_props (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Link signals
   input wire logic ck,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [ddrcsl_pkg::BA_W-1:0] ba,
   input wire logic [ddrcsl_pkg::ADDR_W-1:0] addr
);
   import ddrcsl_pkg::*;
   logic ck_d_ff;
   logic cke_prev_ff;
   logic sref_ff;
   logic [NUM_BANKS-1:0] open_ff;
   logic [NUM_BANKS-1:0] nxt_open;
   // Link clock rise and decoded command
   wire ck_rise = ck && !ck_d_ff;
   wire [2:0] cmd = {ras_n, cas_n, we_n};
   wire sel = !cs_n;
   wire run = ck_rise && cke && cke_prev_ff;
   wire sleep_in = ck_rise && cke_prev_ff && !cke;
   wire wake_up = ck_rise && !cke_prev_ff && cke;
   wire nop_like = cs_n || (cmd == CMD_NOP);
   wire [NUM_BANKS-1:0] bank_sel = NUM_BANKS'(1) << ba;
   wire pre_hit = run && sel && (cmd == CMD_PRE);
   wire [NUM_BANKS-1:0] pre_next = addr[10] ? '0 : (open_ff & ~bank_sel);
   // Open rows seen from the wire
   assign nxt_open = (run && sel && cmd == CMD_ACT) ? (open_ff | bank_sel) :
      pre_hit ? pre_next : open_ff;
   // Helper state, sampled at link clock rises; ck_d_ff every core clock
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ck_d_ff <= 1'b0;
         cke_prev_ff <= 1'b0;
         sref_ff <= 1'b0;
         open_ff <= '0;
      end else begin
         ck_d_ff <= ck;
         if (ck_rise) cke_prev_ff <= cke;
         if (sleep_in) sref_ff <= sel && (cmd == CMD_REF);
         open_ff <= nxt_open;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   property p_pins_hold;
      $rose(ck) |=> $stable({cs_n, cmd, ba, addr}) [*2];
   endproperty
   a_pins_hold: assert property (p_pins_hold)
      else $error("command pins moved while link clock high");
   property p_sleep_cmd;
      sleep_in |-> nop_like || (sel && cmd == CMD_REF);
   endproperty
   a_sleep_cmd: assert property (p_sleep_cmd)
      else $error("bad command at clock enable fall");
   property p_sleep_idle;
      sleep_in |-> open_ff == '0;
   endproperty
   a_sleep_idle: assert property (p_sleep_idle)
      else $error("sleep entered with a row open");
   property p_sref_exit;
      wake_up && sref_ff |-> nop_like;
   endproperty
   a_sref_exit: assert property (p_sref_exit)
      else $error("self refresh left with a real command");
   property p_ref_idle;
      run && sel && (cmd == CMD_REF || cmd == CMD_MRS) |-> open_ff == '0;
   endproperty
   a_ref_idle: assert property (p_ref_idle)
      else $error("refresh or mode set with a row open");
   property p_col_open;
      run && sel && cmd[2:1] == 2'b10 |-> open_ff[ba];
   endproperty
   a_col_open: assert property (p_col_open)
      else $error("column command to a closed bank");
   property p_act_closed;
      run && sel && cmd == CMD_ACT |-> !open_ff[ba];
   endproperty
   a_act_closed: assert property (p_act_closed)
      else $error("activate to an open bank");
   property p_asleep_quiet;
      ck_rise && !cke && !cke_prev_ff |-> nop_like;
   endproperty
   a_asleep_quiet: assert property (p_asleep_quiet)
      else $error("command sent while asleep");
   // Main scenarios reached
   c_sref: cover property (sleep_in && sel && cmd == CMD_REF);
   c_pdn: cover property (sleep_in && nop_like);
   c_wake: cover property (wake_up);
   c_ref: cover property (run && sel && cmd == CMD_REF);
endmodule : ddrcsl_props
`default_nettype wire

// ### tb/tb_ddr_dram_command_state_legality.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ddr_dram_command_state_legality;
   import ddrcsl_pkg::*;
   logic i_clk;
   logic i_rstn;
   logic i_req_valid;
   ddrcsl_req_t i_req_kind;
   logic [BA_W-1:0] i_req_ba;
   logic o_req_ready, o_req_done, o_req_reject;
   logic [5:0] dev1, dev2;
   logic [4*NUM_BANKS-1:0] map1, map2;
   logic ill1, ill2, nop1, nop2, awk1, awk2;
   logic ill_seen, ill1_seen, nop_seen, got;
   int n_mismatch, samples_checked;
   ddrcsl_if lnk1 ();
   ddrcsl_if lnk2 ();
   ddrcsl_ctrl u_ddrcsl_ctrl (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_req_valid(i_req_valid), .i_req_kind(i_req_kind),
      .i_req_ba(i_req_ba), .i_req_addr(13'h0123), .o_req_ready(o_req_ready),
      .o_req_done(o_req_done), .o_req_reject(o_req_reject), .lnk(lnk1));
   ddrcsl_dram u_ddrcsl_dram (.i_clk(i_clk), .i_rstn(i_rstn), .lnk(lnk1),
      .o_dev_state(dev1), .o_bank_idle_map(map1), .o_illegal(ill1),
      .o_nop_taken(nop1), .o_awake(awk1));
   ddrcsl_dram u_ddrcsl_dram_flt (.i_clk(i_clk), .i_rstn(i_rstn), .lnk(lnk2),
      .o_dev_state(dev2), .o_bank_idle_map(map2), .o_illegal(ill2),
      .o_nop_taken(nop2), .o_awake(awk2));
   ddrcsl_props u_ddrcsl_props (.i_clk(i_clk), .i_rstn(i_rstn),
      .ck(lnk1.ck), .cke(lnk1.cke), .cs_n(lnk1.cs_n), .ras_n(lnk1.ras_n),
      .cas_n(lnk1.cas_n), .we_n(lnk1.we_n), .ba(lnk1.ba), .addr(lnk1.addr));
   // Core clock
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // Latch illegal pulses of both ends
   always @(posedge i_clk) begin
      if (ill2 === 1'b1) ill_seen <= 1'b1;
      if (ill1 === 1'b1) ill1_seen <= 1'b1;
      if (nop2 === 1'b1) nop_seen <= 1'b1;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   task automatic cmp_flag(input logic g, input logic e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp_flag
   task automatic cmp_state(input logic [5:0] g, input logic [5:0] e);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp_state
   // One request through the controller, done expected or refused
   task automatic run_req(input ddrcsl_req_t k, input logic [1:0] b,
                          input logic e);
      int i;
      @(negedge i_clk);
      i_req_valid = 1'b1;
      i_req_kind = k;
      i_req_ba = b;
      for (i = 0; i < 200 && !(o_req_done || o_req_reject); i++) begin
         @(negedge i_clk);
      end
      got = o_req_done;
      i_req_valid = 1'b0;
      if (i == 200) begin
         n_mismatch++;
         tally_and_finish();
      end
      cmp_flag(got, e);
   endtask : run_req
   // One link clock frame on the fault-side link
   task automatic frame(input logic ce, input logic cs, input logic [2:0] c,
                        input logic [1:0] b, input logic e);
      @(negedge i_clk);
      ill_seen = 1'b0;
      nop_seen = 1'b0;
      lnk2.cke = ce;
      lnk2.cs_n = cs;
      {lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = c;
      lnk2.ba = b;
      repeat (4) @(negedge i_clk);
      lnk2.ck = 1'b1;
      repeat (4) @(negedge i_clk);
      lnk2.ck = 1'b0;
      lnk2.cs_n = 1'b1;
      {lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = ~c;
      lnk2.ba = ~b;
      repeat (8) @(negedge i_clk);
      cmp_flag(ill_seen, e);
   endtask : frame
   task automatic wait_dev(input logic [5:0] e);
      int i;
      for (i = 0; i < 40 && dev2 !== e; i++) @(negedge i_clk);
      cmp_state(dev2, e);
   endtask : wait_dev
   // Main sequence
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      ill_seen = 1'b0;
      ill1_seen = 1'b0;
      nop_seen = 1'b0;
      i_rstn = 1'b0;
      i_req_valid = 1'b0;
      i_req_kind = DDRCSL_REQ_NOP;
      i_req_ba = 2'h0;
      lnk2.ck = 1'b0;
      lnk2.cke = 1'b1;
      lnk2.cs_n = 1'b1;
      {lnk2.ras_n, lnk2.cas_n, lnk2.we_n} = 3'h7;
      lnk2.ba = 2'h0;
      lnk2.addr = 13'h0;
      repeat (8) @(negedge i_clk);
      i_rstn = 1'b1;
      run_req(DDRCSL_REQ_RD, 2'h0, 1'b0);
      run_req(DDRCSL_REQ_ACT, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_ACT, 2'h0, 1'b0);
      run_req(DDRCSL_REQ_REF, 2'h0, 1'b0);
      run_req(DDRCSL_REQ_SREF, 2'h0, 1'b0);
      run_req(DDRCSL_REQ_RD, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_WR, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_WR, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_BST, 2'h0, 1'b0);
      run_req(DDRCSL_REQ_PRE, 2'h0, 1'b0);
      run_req(DDRCSL_REQ_BST, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_PRE, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_PRE, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_PREA, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_REF, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_MRS, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_NOP, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_SREF, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_RD, 2'h0, 1'b0);
      run_req(DDRCSL_REQ_WAKE, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_PDN, 2'h0, 1'b1);
      run_req(DDRCSL_REQ_WAKE, 2'h0, 1'b1);
      repeat (16) @(negedge i_clk);
      cmp_flag(o_req_ready, 1'b1);
      cmp_flag(ill1_seen, 1'b0);
      $display("test controller requests done");
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      frame(1'b1, 1'b0, CMD_RD, 2'h1, 1'b1);
      frame(1'b1, 1'b0, CMD_ACT, 2'h1, 1'b0);
      frame(1'b1, 1'b0, CMD_ACT, 2'h1, 1'b1);
      frame(1'b1, 1'b0, CMD_REF, 2'h0, 1'b1);
      frame(1'b1, 1'b0, CMD_WR, 2'h1, 1'b0);
      frame(1'b1, 1'b0, CMD_WR, 2'h1, 1'b0);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      frame(1'b1, 1'b0, CMD_PRE, 2'h1, 1'b0);
      frame(1'b1, 1'b0, CMD_PRE, 2'h1, 1'b0);
      cmp_flag(nop_seen, 1'b1);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      cmp_state({2'h0, map2[7:4]}, 6'h01);
      frame(1'b1, 1'b0, CMD_REF, 2'h0, 1'b0);
      wait_dev(DDRCSL_DV_REF);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      wait_dev(DDRCSL_DV_RUN);
      frame(1'b1, 1'b0, CMD_MRS, 2'h0, 1'b0);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      $display("test fault link commands done");
      frame(1'b0, 1'b0, CMD_BST, 2'h0, 1'b1);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      frame(1'b0, 1'b0, CMD_REF, 2'h0, 1'b0);
      wait_dev(DDRCSL_DV_SREF);
      cmp_flag(awk2, 1'b0);
      frame(1'b0, 1'b0, CMD_ACT, 2'h2, 1'b0);
      wait_dev(DDRCSL_DV_SREF);
      // Raise clock enable with the link clock still
      lnk2.cke = 1'b1;
      repeat (8) @(negedge i_clk);
      cmp_flag(awk2, 1'b1);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      wait_dev(DDRCSL_DV_RUN);
      frame(1'b0, 1'b1, CMD_NOP, 2'h0, 1'b0);
      wait_dev(DDRCSL_DV_PDN);
      frame(1'b0, 1'b0, CMD_RD, 2'h0, 1'b0);
      wait_dev(DDRCSL_DV_PDN);
      frame(1'b1, 1'b0, CMD_RD, 2'h0, 1'b0);
      wait_dev(DDRCSL_DV_PDX);
      frame(1'b1, 1'b1, CMD_NOP, 2'h0, 1'b0);
      wait_dev(DDRCSL_DV_RUN);
      frame(1'b0, 1'b0, CMD_REF, 2'h0, 1'b0);
      frame(1'b1, 1'b0, CMD_ACT, 2'h0, 1'b1);
      $display("test power states done");
      tally_and_finish();
   end
endmodule : tb_ddr_dram_command_state_legality
`default_nettype wire
